// >>> inc/sipo_consts.svh
// Constants for the serial-to-parallel latch: widths, pin indices and reset values.
`ifndef SIPO_CONSTS_SVH
`define SIPO_CONSTS_SVH

// ***********************************************************
// Data path sizes.
// ***********************************************************
`define SIPO_WIDTH 8
`define SIPO_FIFO_DEPTH 16

// ***********************************************************
// Bit positions of the pins inside the synchroniser vector.
// ***********************************************************
`define PIN_SHIFT_CLK 0
`define PIN_SERIAL 1
`define PIN_STORAGE_CLK 2
`define PIN_CLEAR_N 3
`define PIN_ENABLE_N 4
`define PIN_COUNT 5

// ***********************************************************
// Reset values.
// ***********************************************************
`define PIN_RESET 5'h18
`define SHIFT_RESET 8'h00
`define STORE_RESET 8'h00
`define OE_N_RESET 8'hFF
`define READY_RESET 1'h0

`endif

// >>> inc/sipo_pkg.sv
// Types shared by the serial-to-parallel latch and its load buffer.
`include "sipo_consts.svh"

package sipo_pkg;

   // One parallel word of the shift and storage registers.
   typedef logic [`SIPO_WIDTH-1:0] word_type;

   // Synchronised pin vector.
   typedef logic [`PIN_COUNT-1:0] pins_type;

endpackage : sipo_pkg

// >>> hdl/sipo_fifo.sv
// Parameterised FIFO that carries loaded words to the storage register.
`timescale 1ns/1ps

module sipo_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   // Clock, reset and enable.
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Filling side.
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Draining side.
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);

   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW-1:0] wr_ptr_ff;
   logic [PW-1:0] nxt_wr_ptr;
   logic [PW-1:0] rd_ptr_ff;
   logic [PW-1:0] nxt_rd_ptr;
   logic [CW-1:0] count_ff;
   logic [CW-1:0] nxt_count;
   logic push;
   logic pop;

   // ***********************************************************
   // Handshake flags: full and empty follow the word count.
   // ***********************************************************
   assign in_ready_o = (count_ff != CW'(DEPTH));
   assign out_valid_o = (count_ff != '0);
   assign out_data_o = mem_ff[rd_ptr_ff];
   assign push = in_valid_i & in_ready_o & ce_i;
   assign pop = out_valid_o & out_ready_i & ce_i;

   // Next pointers and count; the pointers wrap at the depth.
   always_comb
   begin
      nxt_wr_ptr = wr_ptr_ff;
      nxt_rd_ptr = rd_ptr_ff;
      nxt_count = count_ff;
      if (push)
      begin
         nxt_wr_ptr = (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr_ff + 1'b1);
      end
      if (pop)
      begin
         nxt_rd_ptr = (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr_ff + 1'b1);
      end
      if (push && !pop)
      begin
         nxt_count = CW'(count_ff + 1'b1);
      end
      else if (pop && !push)
      begin
         nxt_count = CW'(count_ff - 1'b1);
      end
   end

   // Pointer and count registers.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end
      else
      begin
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         count_ff <= nxt_count;
      end
   end

   // Storage array has no reset; only written entries are ever read.
   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem_ff[wr_ptr_ff] <= in_data_i;
      end
   end

endmodule : sipo_fifo

// >>> hdl/serial_to_parallel_latch_8.sv
// Eight-bit serial-in shift register with a buffered storage register and 3-state outputs.
// How it works
// - Eight-stage shift register feeds an eight-stage storage register, stage for stage.
// - Shift register advances only on a rising shift clock edge.
// - Rising storage clock edge copies the whole shift register into the load buffer, unless the buffer is full.
// - Clocks are independent; outputs hold during shifting until a storage edge.
// - Enable high floats all eight outputs; low drives them from storage.
// - While clear is low, every shift stage is forced to zero.
// - On a shift edge, first stage takes serial input, others the previous stage.
// - A falling shift clock edge leaves the shift register unchanged.
// - Storage holds its value except when a buffered word is drained with HOLD_OUT_I low.
`timescale 1ns/1ps
`include "sipo_consts.svh"

module serial_to_parallel_latch_8
   import sipo_pkg::*;
(
   // System clock, reset and clock enable.
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   input wire logic CE_I,
   // Serial pins from the controller.
   input wire logic SHIFT_CLOCK_I,
   input wire logic SERIAL_I,
   input wire logic STORAGE_CLOCK_I,
   input wire logic CLEAR_SHIFT_N_I,
   input wire logic ENABLE_OUT_N_I,
   // Draining control from local logic on the system clock.
   input wire logic HOLD_OUT_I,
   // Parallel 3-state outputs, enables active low.
   output logic [`SIPO_WIDTH-1:0] PARALLEL_OUT_O,
   output logic [`SIPO_WIDTH-1:0] PARALLEL_OE_N_O,
   // Cascade output and buffer status.
   output logic CASCADE_OUT_O,
   output logic LOAD_READY_O
);

   // ***********************************************************
   // Pin synchronisers and edge detection.
   // ***********************************************************
   pins_type pin_meta_ff;
   pins_type pin_sync_ff;
   pins_type pin_prev_ff;
   pins_type nxt_pin_meta;
   pins_type nxt_pin_sync;
   pins_type nxt_pin_prev;
   pins_type pins_raw;
   logic shift_rise;
   logic store_rise;
   logic clear_act;
   logic serial_bit;

   assign pins_raw = {ENABLE_OUT_N_I, CLEAR_SHIFT_N_I, STORAGE_CLOCK_I, SERIAL_I, SHIFT_CLOCK_I};

   // Two flops per pin, then one more flop used only for edge finding.
   always_comb
   begin
      nxt_pin_meta = pin_meta_ff;
      nxt_pin_sync = pin_sync_ff;
      nxt_pin_prev = pin_prev_ff;
      if (CE_I)
      begin
         nxt_pin_meta = pins_raw;
         nxt_pin_sync = pin_meta_ff;
         nxt_pin_prev = pin_sync_ff;
      end
   end

   // Synchroniser registers; idle levels keep clear off and outputs floated.
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         pin_meta_ff <= `PIN_RESET;
         pin_sync_ff <= `PIN_RESET;
         pin_prev_ff <= `PIN_RESET;
      end
      else
      begin
         pin_meta_ff <= nxt_pin_meta;
         pin_sync_ff <= nxt_pin_sync;
         pin_prev_ff <= nxt_pin_prev;
      end
   end

   // Rising edges only; falling edges are ignored by construction.
   assign shift_rise = pin_sync_ff[`PIN_SHIFT_CLK] & ~pin_prev_ff[`PIN_SHIFT_CLK];
   assign store_rise = pin_sync_ff[`PIN_STORAGE_CLK] & ~pin_prev_ff[`PIN_STORAGE_CLK];
   assign clear_act = ~pin_sync_ff[`PIN_CLEAR_N];
   assign serial_bit = pin_sync_ff[`PIN_SERIAL];

   // ***********************************************************
   // Shift register.
   // ***********************************************************
   word_type shift_ff;
   word_type nxt_shift;

   // Clear dominates; otherwise a rising shift edge moves every stage up one.
   always_comb
   begin
      nxt_shift = shift_ff;
      if (CE_I)
      begin
         if (clear_act)
         begin
            nxt_shift = `SHIFT_RESET;
         end
         else if (shift_rise)
         begin
            nxt_shift = {shift_ff[`SIPO_WIDTH-2:0], serial_bit};
         end
      end
   end

   // Shift register flops; the top stage doubles as the cascade output.
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         shift_ff <= `SHIFT_RESET;
      end
      else
      begin
         shift_ff <= nxt_shift;
      end
   end

   assign CASCADE_OUT_O = shift_ff[`SIPO_WIDTH-1];

   // ***********************************************************
   // Load buffer between shift and storage registers.
   // ***********************************************************
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic pop_fire;
   word_type fifo_out_data;

   // A storage edge pushes a snapshot of all stages at once.
   sipo_fifo
   #(
      .WIDTH(`SIPO_WIDTH),
      .DEPTH(`SIPO_FIFO_DEPTH)
   )
   load_buf
   (
      .clk_i(CLK_SYS_I),
      .rst_i(RST_I),
      .ce_i(CE_I),
      .in_valid_i(store_rise),
      .in_ready_o(fifo_in_ready),
      .in_data_i(shift_ff),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(~HOLD_OUT_I),
      .out_data_o(fifo_out_data)
   );

   assign pop_fire = CE_I & fifo_out_valid & ~HOLD_OUT_I;

   // ***********************************************************
   // Storage register and output drivers.
   // ***********************************************************
   word_type store_ff;
   word_type nxt_store;
   logic [`SIPO_WIDTH-1:0] oe_n_ff;
   logic [`SIPO_WIDTH-1:0] nxt_oe_n;
   logic ready_ff;
   logic nxt_ready;

   // Storage loads only from the buffer, so clearing and shifting never touch it.
   always_comb
   begin
      nxt_store = store_ff;
      nxt_oe_n = oe_n_ff;
      nxt_ready = ready_ff;
      if (CE_I)
      begin
         if (pop_fire)
         begin
            nxt_store = fifo_out_data;
         end
         nxt_oe_n = {`SIPO_WIDTH{pin_sync_ff[`PIN_ENABLE_N]}};
         nxt_ready = fifo_in_ready;
      end
   end

   // Output registers.
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         store_ff <= `STORE_RESET;
         oe_n_ff <= `OE_N_RESET;
         ready_ff <= `READY_RESET;
      end
      else
      begin
         store_ff <= nxt_store;
         oe_n_ff <= nxt_oe_n;
         ready_ff <= nxt_ready;
      end
   end

   assign PARALLEL_OUT_O = store_ff;
   assign PARALLEL_OE_N_O = oe_n_ff;
   assign LOAD_READY_O = ready_ff;

   // ***********************************************************
   // Assertions.
   // ***********************************************************
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (RST_I);

   // A quiet cycle: enabled, no clear and no rising shift edge.
   sequence shift_quiet_s;
      CE_I && !clear_act && !shift_rise;
   endsequence

   // A storage edge into an empty buffer followed by an open drain cycle.
   sequence load_path_s;
      (CE_I && store_rise && !fifo_out_valid && !HOLD_OUT_I) ##1 (CE_I && !HOLD_OUT_I);
   endsequence

   shift_hold_a: assert property (shift_quiet_s |=> $stable(shift_ff))
      else $error("Shift register moved without a rising shift edge.");

   shift_step_a: assert property ((CE_I && !clear_act && shift_rise)
      |=> shift_ff == {$past(shift_ff[`SIPO_WIDTH-2:0]), $past(serial_bit)})
      else $error("Shift step did not take serial bit and previous stages.");

   clear_zero_a: assert property ((CE_I && clear_act) |=> shift_ff == `SHIFT_RESET)
      else $error("Shift register not zero while clear was active.");

   store_copy_a: assert property (load_path_s |=> store_ff == $past(shift_ff, 2))
      else $error("Storage did not take the shift contents of the storage edge.");

   store_keep_a: assert property (!pop_fire |=> $stable(store_ff))
      else $error("Storage changed without a load.");

   store_cause_a: assert property ($changed(store_ff) |-> $past(pop_fire))
      else $error("Parallel outputs changed while only shifting.");

   oe_follow_a: assert property (CE_I |=> PARALLEL_OE_N_O
      == {`SIPO_WIDTH{$past(pin_sync_ff[`PIN_ENABLE_N])}})
      else $error("Output enables do not follow the enable pin.");

   cascade_step_a: assert property ((CE_I && !clear_act && shift_rise)
      |=> CASCADE_OUT_O == $past(shift_ff[`SIPO_WIDTH-2]))
      else $error("Cascade output did not take the seventh stage.");

   clear_keep_a: assert property ((CE_I && clear_act && !pop_fire) |=> $stable(store_ff))
      else $error("Clearing the shift register altered storage.");

endmodule : serial_to_parallel_latch_8

// >>> testbench/host_link_model.sv
// Behavioural host controller that drives the serial pins of the latch on an 80 ns link clock.
`timescale 1ns/1ps

module host_link_model
   import sipo_pkg::*;
(
   // System clock and request from the bench.
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic shift_i,
   input wire logic latch_i,
   input wire word_type word_i,
   // Pins towards the latch and request status.
   output logic shift_clk_o,
   output logic serial_o,
   output logic storage_clk_o,
   output logic busy_o
);
   word_type data;
   logic do_shift;
   logic do_latch;

   // One link period is 10 system cycles low and 10 high; the clock stands low between frames.
   initial
   begin
      shift_clk_o = 1'b0;
      serial_o = 1'b0;
      storage_clk_o = 1'b0;
      busy_o = 1'b0;
      forever
      begin
         @(posedge clk_i);
         if (go_i && !busy_o)
         begin
            busy_o <= 1'b1;
            data = word_i;
            do_shift = shift_i;
            do_latch = latch_i;
            for (int i = 7; i >= 0 && do_shift; i--)
            begin
               serial_o <= data[i];
               repeat (10) @(posedge clk_i);
               shift_clk_o <= 1'b1;
               repeat (5) @(posedge clk_i);
               serial_o <= ~data[i]; // Data is only valid around the rising edge.
               repeat (5) @(posedge clk_i);
               shift_clk_o <= 1'b0;
            end
            if (do_latch)
            begin
               repeat (10) @(posedge clk_i);
               storage_clk_o <= 1'b1;
               repeat (10) @(posedge clk_i);
               storage_clk_o <= 1'b0;
            end
            repeat (10) @(posedge clk_i);
            busy_o <= 1'b0;
         end
      end
   end
endmodule : host_link_model

// >>> testbench/serial_to_parallel_latch_8_test.sv
// Self-checking bench for the serial-to-parallel latch and its load buffer.
`timescale 1ns/1ps

module test_serial_to_parallel_latch_8
   import sipo_pkg::*;
;
   logic clk = 1'b0;
   logic rst, ce, clear_n, enable_n, hold, go, shift, latch;
   logic sclk, sdat, rclk, busy, casc, ready;
   word_type word, par, oe_n, w, last_exp, last_seen;
   word_type exp_q[$];
   int seed = 32'h2D28;
   int num_errors = 0;
   int checks_done = 0;

   // The system clock runs at 250 MHz.
   always #2 clk = ~clk;

   host_link_model i_host (.clk_i(clk), .go_i(go), .shift_i(shift), .latch_i(latch),
      .word_i(word), .shift_clk_o(sclk), .serial_o(sdat), .storage_clk_o(rclk), .busy_o(busy));

   serial_to_parallel_latch_8 i_dut (.CLK_SYS_I(clk), .RST_I(rst), .CE_I(ce),
      .SHIFT_CLOCK_I(sclk), .SERIAL_I(sdat), .STORAGE_CLOCK_I(rclk),
      .CLEAR_SHIFT_N_I(clear_n), .ENABLE_OUT_N_I(enable_n), .HOLD_OUT_I(hold),
      .PARALLEL_OUT_O(par), .PARALLEL_OE_N_O(oe_n), .CASCADE_OUT_O(casc), .LOAD_READY_O(ready));

   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("Mismatches %0d, checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results

   // Compares one word.
   task automatic check8(input string what, input word_type exp, input word_type got);
      checks_done++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask : check8

   // Compares one bit.
   task automatic check1(input string what, input logic exp, input logic got);
      checks_done++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
         num_errors++;
      end
   endtask : check1

   // Waits a bounded time for the host model to reach the given busy level.
   task automatic wait_busy(input logic lvl);
      for (int n = 0; n < 1000; n++)
      begin
         @(posedge clk);
         if (busy === lvl)
            return;
      end
      $display("[FAIL] host busy expected %b seen %b", lvl, busy);
      num_errors++;
      results();
   endtask : wait_busy

   // Runs one host request; a stored word is noted in the queue beforehand.
   task automatic send(input word_type v, input logic sh, input logic la, input logic q,
                       input word_type e);
      if (q)
      begin
         exp_q.push_back(e);
         last_exp = e;
      end
      word <= v;
      shift <= sh;
      latch <= la;
      go <= 1'b1;
      wait_busy(1'b1);
      go <= 1'b0;
      wait_busy(1'b0);
   endtask : send

   // Random nonzero word that differs from the last stored one.
   function automatic word_type fresh();
      word_type r;
      do
         r = word_type'($random(seed));
      while (r == last_exp || r == 8'h00);
      return r;
   endfunction : fresh

   // Every change of the parallel outputs must match the oldest noted word.
   always @(posedge clk)
   begin
      if (!rst && par !== last_seen)
      begin
         check8("parallel", (exp_q.size() > 0) ? exp_q.pop_front() : last_seen, par);
         last_seen = par;
      end
   end

   // Main sequence.
   initial
   begin
      {rst, ce, clear_n, enable_n, hold, go, shift, latch} = 8'hF0;
      word = 8'h00;
      last_exp = 8'h00;
      last_seen = 8'h00;
      repeat (4) @(posedge clk);
      check8("reset out", 8'h00, par);
      check8("reset oe", 8'hFF, oe_n);
      check1("reset cascade", 1'b0, casc);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      // Words shifted and stored one by one, with the enable toggling meanwhile.
      for (int k = 0; k < 6; k++)
      begin
         enable_n <= k[0];
         w = fresh();
         send(w, 1'b1, 1'b1, 1'b1, w);
         check1("cascade", w[7], casc);
         check8("enable", {8{k[0]}}, oe_n);
      end
      // Shifting alone leaves the outputs; a later storage edge alone loads them.
      w = fresh();
      send(w, 1'b1, 1'b0, 1'b0, 8'h00);
      send(8'h00, 1'b0, 1'b1, 1'b1, w);
      // Clear empties the shift register but not the outputs.
      clear_n <= 1'b0;
      repeat (8) @(posedge clk);
      check1("cleared cascade", 1'b0, casc);
      clear_n <= 1'b1;
      repeat (4) @(posedge clk);
      send(8'h00, 1'b0, 1'b1, 1'b1, 8'h00);
      // With the clock enable low the whole request is ignored.
      ce <= 1'b0;
      send(fresh(), 1'b1, 1'b1, 1'b0, 8'h00);
      ce <= 1'b1;
      repeat (4) @(posedge clk);
      check1("frozen cascade", 1'b0, casc);
      // Fill the load buffer while draining is stalled, then overflow it once.
      hold <= 1'b1;
      for (int k = 0; k < 16; k++)
      begin
         w = fresh();
         send(w, 1'b1, 1'b1, 1'b1, w);
      end
      check1("ready full", 1'b0, ready);
      w = fresh();
      send(w, 1'b1, 1'b1, 1'b0, 8'h00);
      hold <= 1'b0;
      repeat (40) @(posedge clk);
      check8("words left", 8'h00, 8'(exp_q.size()));
      check1("ready drained", 1'b1, ready);
      send(8'h00, 1'b0, 1'b1, 1'b1, w);
      repeat (10) @(posedge clk);
      check8("words left", 8'h00, 8'(exp_q.size()));
      results();
   end
endmodule : test_serial_to_parallel_latch_8
